// ===== rtl/eptm_timer.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// Operation
// - Three channels 0..2, each event counting or measurement mode by mode register.
// - Event source: own pin on rising, falling or both edges, or neighbour underflow or overflow.
// - Event mode decrements per event; on underflow reloads and continues.
// - Event mode gives one underflow every n+1 events.
// - Counting runs only while the channel start flag is 1.
// - Event mode raises interrupt request on each underflow.
// - Event mode timer read returns live counter.
// - Event mode write while stopped loads reload register and counter.
// - Event mode write while running loads reload register only.
// - Measurement mode times pulse period or pulse width on input edges.
// - Measurement raises interrupt request on each effective edge.
// - First effective edge after counting starts raises no request.
// - Measurement overflow raises request and sets overflow flag together.
// - Mode write while started clears overflow flag after next count tick.
// - Measurement timer read returns reload register, the latest result.
// - Measurement mode ignores timer register writes.
// - Result undefined before the second effective edge after start.
// - Channel 0 pin has noise filter; bits 2..4 enable and pick its clock.
// - Mode register bits 0 and 1 choose the operating mode.
module eptm_timer
  import eptm_pkg::*;
#(
  parameter int NCH = 3,
  parameter int TW  = 16
) (
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire logic           ce,
  input  wire logic [3:0]     reg_addr,
  input  wire logic [TW-1:0]  reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [TW-1:0]  reg_rdata,
  input  wire logic [NCH-1:0] channel_event_pin,
  input  wire logic           subclk,
  output logic      [NCH-1:0] irq_req
);

  initial begin
    if (NCH != 3) $error("eptm_timer: NCH must be 3");
    if (TW != 16) $error("eptm_timer: TW must be 16");
  end

  // ===========================================================
  // Shared decoding
  function automatic logic edge_match(input logic [1:0] sel,
                                      input logic       rise,
                                      input logic       fall);
    case (sel)
      EPTM_EDGE_FALL: edge_match = fall;
      EPTM_EDGE_RISE: edge_match = rise;
      default:        edge_match = rise | fall;
    endcase
  endfunction

  function automatic logic tick_sel(input logic [1:0] sel,
                                    input logic       t1,
                                    input logic       t8,
                                    input logic       t32,
                                    input logic       tsub);
    case (sel)
      EPTM_CK_F1:  tick_sel = t1;
      EPTM_CK_F8:  tick_sel = t8;
      EPTM_CK_F32: tick_sel = t32;
      default:     tick_sel = tsub;
    endcase
  endfunction

  // ===========================================================
  // Prescaler taps
  logic [4:0] presc_r;
  logic       tick_f8;
  logic       tick_f32;

  always_ff @(posedge clk) begin
    if (srst) begin
      presc_r <= '0;
    end else if (ce) begin
      presc_r <= presc_r + 5'h01;
    end
  end

  assign tick_f8  = (presc_r & EPTM_DIV8_MASK) == EPTM_DIV8_MASK;
  assign tick_f32 = presc_r == EPTM_DIV32_LAST;

  // ===========================================================
  // Input synchronisers
  logic [NCH-1:0] pin_sync;
  logic           sub_sync;

  eptm_sync #(.W(NCH + 1)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .async_in ({subclk, channel_event_pin}),
    .sync_out ({sub_sync, pin_sync})
  );

  // Subclock divided by 32
  logic       sub_prev_r;
  logic [4:0] subdiv_r;
  logic       tick_sub_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      sub_prev_r <= 1'b0;
      subdiv_r   <= '0;
      tick_sub_r <= 1'b0;
    end else if (ce) begin
      sub_prev_r <= sub_sync;
      tick_sub_r <= 1'b0;
      if (sub_sync && !sub_prev_r) begin
        subdiv_r   <= subdiv_r + 5'h01;
        tick_sub_r <= subdiv_r == EPTM_DIV32_LAST;
      end
    end
  end

  // ===========================================================
  // Global control registers
  logic [NCH-1:0] start_r;
  logic [7:0]     periph_r;
  logic [NCH-1:0] start_prev_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      start_r <= '0;
    end else if (ce && reg_wr && reg_addr == EPTM_ADDR_START) begin
      start_r <= reg_wdata[NCH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      periph_r <= EPTM_PERIPH_RST;
    end else if (ce && reg_wr && reg_addr == EPTM_ADDR_PERIPH) begin
      // Bit 7 is held for software; the filter itself ignores it
      periph_r <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      start_prev_r <= '0;
    end else if (ce) begin
      start_prev_r <= start_r;
    end
  end

  // ===========================================================
  // Channel 0 noise filter
  logic filtered_channel0_pin;
  logic flt_tick;

  assign flt_tick = tick_sel(periph_r[EPTM_FLT_CK_LSB +: 2], 1'b1,
                             tick_f8, tick_f32, tick_sub_r);

  eptm_filter #(.DEPTH(EPTM_FLT_DEPTH)) u_filter (
    .clk         (clk),
    .srst        (srst),
    .ce          (ce),
    .enable      (periph_r[EPTM_FLT_EN_BIT]),
    .sample_tick (flt_tick),
    .din         (pin_sync[0]),
    .dout        (filtered_channel0_pin)
  );

  // ===========================================================
  // Per-channel edge detection
  logic [NCH-1:0] pin_use;
  logic [NCH-1:0] pin_prev_r;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;

  assign pin_use = {pin_sync[NCH-1:1], filtered_channel0_pin};
  assign rise    = pin_use & ~pin_prev_r;
  assign fall    = ~pin_use & pin_prev_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_prev_r <= '0;
    end else if (ce) begin
      pin_prev_r <= pin_use;
    end
  end

  // ===========================================================
  // Channels
  logic [NCH-1:0] wrap_r;
  logic [TW-1:0]  cnt_w  [NCH];
  logic [TW-1:0]  rld_w  [NCH];
  logic [7:0]     mode_w [NCH];

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      localparam int NB = (gi + NCH - 1) % NCH;
      localparam logic [3:0] A_MODE = EPTM_ADDR_MODE0 + 4'(gi);
      localparam logic [3:0] A_TMR  = EPTM_ADDR_TMR0 + 4'(gi);

      logic [7:0]    mode_r;
      logic [TW-1:0] cnt_r;
      logic [TW-1:0] rld_r;
      logic          ovf_r;
      logic          clr_pend_r;
      logic          first_r;
      logic          irq_r;
      logic          wrap_nxt;
      logic          is_evt;
      logic          is_meas;
      logic          run;
      logic          evt_tick;
      logic          meas_tick;
      logic          meas_edge;
      logic          wr_mode;
      logic          wr_tmr;

      assign is_evt  = mode_r[EPTM_MODE_LSB +: 2] == EPTM_MODE_EVENT;
      assign is_meas = mode_r[EPTM_MODE_LSB +: 2] == EPTM_MODE_MEASURE;
      assign run     = start_r[gi];
      assign wr_mode = ce && reg_wr && reg_addr == A_MODE;
      assign wr_tmr  = ce && reg_wr && reg_addr == A_TMR;

      // Neighbour wrap is a registered pulse, so no loop forms
      assign evt_tick = mode_r[EPTM_EVSRC_BIT] ? wrap_r[NB]
                      : edge_match(mode_r[EPTM_EDGE_LSB +: 2],
                                   rise[gi], fall[gi]);
      assign meas_tick = tick_sel(mode_r[EPTM_CKSEL_LSB +: 2], 1'b1,
                                  tick_f8, tick_f32, tick_sub_r);
      assign meas_edge = edge_match(mode_r[EPTM_EDGE_LSB +: 2],
                                    rise[gi], fall[gi]);

      always_ff @(posedge clk) begin
        if (srst) begin
          mode_r <= EPTM_MODE_RST;
        end else if (wr_mode) begin
          mode_r <= reg_wdata[7:0];
        end
      end

      // Counter and reload register
      always_ff @(posedge clk) begin
        if (srst) begin
          cnt_r <= EPTM_TMR_RST;
          rld_r <= EPTM_TMR_RST;
        end else if (ce) begin
          if (is_evt) begin
            if (run && evt_tick) begin
              if (cnt_r == EPTM_TMR_RST) begin
                cnt_r <= rld_r;
              end else begin
                cnt_r <= cnt_r - 16'h0001;
              end
            end
            if (wr_tmr) begin
              rld_r <= reg_wdata;
              if (!run) begin
                cnt_r <= reg_wdata;
              end
            end
          end else if (is_meas) begin
            // Writes are dropped here
            if (run && meas_edge) begin
              rld_r <= cnt_r;
              cnt_r <= EPTM_TMR_RST;
            end else if (run && meas_tick) begin
              cnt_r <= cnt_r + 16'h0001;
            end
          end else if (wr_tmr) begin
            rld_r <= reg_wdata;
            if (!run) begin
              cnt_r <= reg_wdata;
            end
          end
        end
      end

      // First-edge suppression after each start
      always_ff @(posedge clk) begin
        if (srst) begin
          first_r <= 1'b1;
        end else if (ce) begin
          if (run && !start_prev_r[gi]) begin
            first_r <= 1'b1;
          end else if (is_meas && run && meas_edge) begin
            first_r <= 1'b0;
          end
        end
      end

      // Overflow flag: set beats the pending clear
      always_ff @(posedge clk) begin
        if (srst) begin
          ovf_r      <= 1'b0;
          clr_pend_r <= 1'b0;
        end else if (ce) begin
          if (is_meas && run && meas_tick && !meas_edge &&
              cnt_r == EPTM_TMR_MAX) begin
            ovf_r      <= 1'b1;
            clr_pend_r <= wr_mode && run;
          end else if (clr_pend_r && meas_tick) begin
            ovf_r      <= 1'b0;
            clr_pend_r <= wr_mode && run;
          end else if (wr_mode && run) begin
            clr_pend_r <= 1'b1;
          end
        end
      end

      always_comb begin
        wrap_nxt = 1'b0;
        if (run && is_evt && evt_tick && cnt_r == EPTM_TMR_RST) begin
          wrap_nxt = 1'b1;
        end else if (run && is_meas && meas_tick && !meas_edge &&
                     cnt_r == EPTM_TMR_MAX) begin
          wrap_nxt = 1'b1;
        end
      end

      // Request pulses, one cycle each
      always_ff @(posedge clk) begin
        if (srst) begin
          irq_r      <= 1'b0;
          wrap_r[gi] <= 1'b0;
        end else if (ce) begin
          wrap_r[gi] <= wrap_nxt;
          irq_r      <= wrap_nxt ||
                        (is_meas && run && meas_edge && !first_r);
        end else begin
          irq_r      <= 1'b0;
          wrap_r[gi] <= 1'b0;
        end
      end

      assign irq_req[gi] = irq_r;
      assign cnt_w[gi]   = cnt_r;
      assign rld_w[gi]   = rld_r;
      assign mode_w[gi]  = {mode_r[7:EPTM_OVF_BIT+1], ovf_r,
                            mode_r[EPTM_OVF_BIT-1:0]};
    end
  endgenerate

  // ===========================================================
  // Read port, data one cycle after the strobe
  logic [TW-1:0] rd_nxt;

  function automatic logic [TW-1:0] tmr_view(input logic [7:0]    md,
                                             input logic [TW-1:0] c,
                                             input logic [TW-1:0] r);
    // Result is only meaningful after the second edge
    if (md[EPTM_MODE_LSB +: 2] == EPTM_MODE_MEASURE) begin
      tmr_view = r;
    end else begin
      tmr_view = c;
    end
  endfunction

  always_comb begin
    rd_nxt = '0;
    case (reg_addr)
      EPTM_ADDR_MODE0:  rd_nxt = {8'h00, mode_w[0]};
      EPTM_ADDR_MODE1:  rd_nxt = {8'h00, mode_w[1]};
      EPTM_ADDR_MODE2:  rd_nxt = {8'h00, mode_w[2]};
      EPTM_ADDR_TMR0:   rd_nxt = tmr_view(mode_w[0], cnt_w[0], rld_w[0]);
      EPTM_ADDR_TMR1:   rd_nxt = tmr_view(mode_w[1], cnt_w[1], rld_w[1]);
      EPTM_ADDR_TMR2:   rd_nxt = tmr_view(mode_w[2], cnt_w[2], rld_w[2]);
      EPTM_ADDR_START:  rd_nxt = {13'h0000, start_r};
      EPTM_ADDR_PERIPH: rd_nxt = {8'h00, periph_r};
      default:          rd_nxt = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (ce && reg_rd) begin
      reg_rdata <= rd_nxt;
    end
  end

endmodule

// ===== inc/eptm_pkg.sv
package eptm_pkg;

  // ===========================================================
  // Register map (word index on the plain register port)
  localparam logic [3:0] EPTM_ADDR_MODE0  = 4'h0;
  localparam logic [3:0] EPTM_ADDR_MODE1  = 4'h1;
  localparam logic [3:0] EPTM_ADDR_MODE2  = 4'h2;
  localparam logic [3:0] EPTM_ADDR_TMR0   = 4'h4;
  localparam logic [3:0] EPTM_ADDR_TMR1   = 4'h5;
  localparam logic [3:0] EPTM_ADDR_TMR2   = 4'h6;
  localparam logic [3:0] EPTM_ADDR_START  = 4'h8;
  localparam logic [3:0] EPTM_ADDR_PERIPH = 4'h9;

  // ===========================================================
  // Mode register fields
  localparam int EPTM_MODE_LSB   = 0;
  localparam int EPTM_EDGE_LSB   = 2;
  localparam int EPTM_EVSRC_BIT  = 4;
  localparam int EPTM_OVF_BIT    = 5;
  localparam int EPTM_CKSEL_LSB  = 6;

  localparam logic [1:0] EPTM_MODE_TIMER   = 2'h0;
  localparam logic [1:0] EPTM_MODE_EVENT   = 2'h1;
  localparam logic [1:0] EPTM_MODE_MEASURE = 2'h2;

  // Edge select: falling, rising, both
  localparam logic [1:0] EPTM_EDGE_FALL = 2'h0;
  localparam logic [1:0] EPTM_EDGE_RISE = 2'h1;

  // Count source select: f1, f8, f32, subclock/32
  localparam logic [1:0] EPTM_CK_F1   = 2'h0;
  localparam logic [1:0] EPTM_CK_F8   = 2'h1;
  localparam logic [1:0] EPTM_CK_F32  = 2'h2;

  // ===========================================================
  // Peripheral mode register fields
  localparam int EPTM_FLT_EN_BIT  = 2;
  localparam int EPTM_FLT_CK_LSB  = 3;
  localparam int EPTM_MCLK_BIT    = 7;

  // ===========================================================
  // Reset values and timing counts
  localparam logic [7:0]  EPTM_MODE_RST   = 8'h00;
  localparam logic [7:0]  EPTM_PERIPH_RST = 8'h00;
  localparam logic [15:0] EPTM_TMR_RST    = 16'h0000;
  localparam logic [15:0] EPTM_TMR_MAX    = 16'hffff;
  localparam logic [4:0]  EPTM_DIV8_MASK  = 5'h07;
  localparam logic [4:0]  EPTM_DIV32_LAST = 5'h1f;
  localparam int          EPTM_FLT_DEPTH  = 3;

endpackage

// ===== rtl/eptm_sync.sv
`timescale 1ns/10ps
module eptm_sync
  import eptm_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ===========================================================
  // Two-stage synchroniser; first stage feeds only the second
  logic [W-1:0] meta_r;

  initial begin
    if (W < 1) $error("eptm_sync: W must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ===== rtl/eptm_filter.sv
`timescale 1ns/10ps
module eptm_filter
  import eptm_pkg::*;
#(
  parameter int DEPTH = EPTM_FLT_DEPTH
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic sample_tick,
  input  wire logic din,
  output logic      dout
);

  // ===========================================================
  // Majority-free filter: output moves only after DEPTH equal samples
  logic [DEPTH-1:0] hist_r;

  initial begin
    if (DEPTH < 2) $error("eptm_filter: DEPTH must be at least 2");
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hist_r <= '0;
    end else if (ce && sample_tick) begin
      hist_r <= {hist_r[DEPTH-2:0], din};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dout <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        dout <= din;
      end else if (&hist_r) begin
        dout <= 1'b1;
      end else if (~|hist_r) begin
        dout <= 1'b0;
      end
    end
  end

endmodule

// ===== sim/eptm_timer_asserts.sv
`timescale 1ns/10ps
module eptm_chk
  import eptm_pkg::*;
#(
  parameter int NCH = 3,
  parameter int TW  = 16
) (
  input wire logic           clk,
  input wire logic           srst,
  input wire logic           ce,
  input wire logic [3:0]     reg_addr,
  input wire logic [TW-1:0]  reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [TW-1:0]  reg_rdata,
  input wire logic [NCH-1:0] channel_event_pin,
  input wire logic           subclk,
  input wire logic [NCH-1:0] irq_req
);
  // ============================================================
  // Shadow of the software-visible control state
  logic [NCH-1:0] start_r;
  logic [7:0]     mode_r [NCH];
  logic [7:0]     periph_r;
  logic [NCH-1:0] idle;
  logic           wr_ok;
  assign wr_ok = reg_wr && ce;
  always_ff @(posedge clk) begin
    if (srst) begin
      start_r  <= '0;
      periph_r <= EPTM_PERIPH_RST;
    end else if (wr_ok && reg_addr == EPTM_ADDR_START) begin
      start_r <= reg_wdata[NCH-1:0];
    end else if (wr_ok && reg_addr == EPTM_ADDR_PERIPH) begin
      periph_r <= reg_wdata[7:0];
    end
  end
  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst) mode_r[i] <= EPTM_MODE_RST;
      else if (wr_ok && reg_addr == 4'(i)) mode_r[i] <= reg_wdata[7:0];
    end
  end
  always_comb begin
    for (int i = 0; i < NCH; i++) idle[i] = mode_r[i][1:0] == 2'h0;
  end
  // ============================================================
  // Properties; two-deep history covers a late request pulse
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_rst;
    $fell(srst) |-> reg_rdata == '0 && irq_req == '0;
  endproperty
  property p_hold;
    !$past(reg_rd) |-> $stable(reg_rdata);
  endproperty
  property p_unmap;
    reg_rd && reg_addr inside {4'h3, 4'h7, [4'ha:4'hf]} |=> reg_rdata == '0;
  endproperty
  property p_start;
    reg_rd && reg_addr == EPTM_ADDR_START
      |=> reg_rdata == {{(TW-NCH){1'b0}}, start_r};
  endproperty
  property p_mode;
    reg_rd && reg_addr <= EPTM_ADDR_MODE2 |=> reg_rdata[15:8] == 8'h00
      && {reg_rdata[7:6], reg_rdata[4:0]} == {mode_r[$past(reg_addr[1:0])][7:6],
         mode_r[$past(reg_addr[1:0])][4:0]};
  endproperty
  property p_periph;
    reg_rd && reg_addr == EPTM_ADDR_PERIPH |=> reg_rdata[15:8] == 8'h00
      && {reg_rdata[7], reg_rdata[4:2]} == {periph_r[7], periph_r[4:2]};
  endproperty
  property p_stop;
    (irq_req & ~$past(start_r) & ~$past(start_r, 2)) == '0;
  endproperty
  property p_idle;
    (irq_req & $past(idle) & $past(idle, 2)) == '0;
  endproperty
  property p_freeze;
    !ce ##1 !ce |-> irq_req == '0;
  endproperty
  a_rst:    assert property (p_rst) else $error("bad reset state");
  a_hold:   assert property (p_hold) else $error("read data moved");
  a_unmap:  assert property (p_unmap) else $error("unmapped not 0");
  a_start:  assert property (p_start) else $error("start readback");
  a_mode:   assert property (p_mode) else $error("mode readback");
  a_periph: assert property (p_periph) else $error("periph readback");
  a_stop:   assert property (p_stop) else $error("request stopped");
  a_idle:   assert property (p_idle) else $error("request in idle");
  a_freeze: assert property (p_freeze) else $error("request frozen");
  c_ev:   cover property (irq_req[1]);
  c_nb:   cover property (irq_req[0]);
  c_meas: cover property (irq_req[2]);
endmodule

bind eptm_timer eptm_chk #(.NCH(NCH), .TW(TW)) u_chk (
  .clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .channel_event_pin(channel_event_pin),
  .subclk(subclk), .irq_req(irq_req)
);

// ===== sim/eptm_pulse_src.sv
`timescale 1ns/10ps
module eptm_pulse_src #(
  parameter int NCH  = 3,
  parameter int HALF = 5
) (
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire logic [NCH-1:0] toggle,
  output logic      [NCH-1:0] channel_event_pin,
  output logic                subclk
);
  // ============================================================
  // Level source: a pin holds its level until told to flip
  int div_r;
  always_ff @(posedge clk) begin
    if (srst) channel_event_pin <= '0;
    else channel_event_pin <= channel_event_pin ^ toggle;
  end
  // Subclock runs free, it is not gated by frames
  always_ff @(posedge clk) begin
    if (srst || div_r == HALF - 1) div_r <= 0;
    else div_r <= div_r + 1;
  end
  always_ff @(posedge clk) begin
    if (srst) subclk <= 1'b0;
    else if (div_r == HALF - 1) subclk <= ~subclk;
  end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps
module testbench
  import eptm_pkg::*;
;
  logic        clk;
  logic        srst;
  logic        ce;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [2:0]  pins;
  logic [2:0]  toggle;
  logic        subclk;
  logic [2:0]  irq_req;
  logic        rd_d;
  logic [15:0] exp_v;
  logic [15:0] lfsr;
  logic [15:0] n;
  logic [15:0] exp_q [$];
  int          num_errors;
  int          comparisons;
  int          cyc;
  int          irq_cnt [3];
  int          exp1;

  eptm_timer #(.NCH(3), .TW(16)) DUT (
    .clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .channel_event_pin(pins),
    .subclk(subclk), .irq_req(irq_req)
  );
  eptm_pulse_src #(.NCH(3)) u_src (
    .clk(clk), .srst(srst), .toggle(toggle),
    .channel_event_pin(pins), .subclk(subclk)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ============================================================
  // Bus and pin tasks; one idle edge between accesses
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic tog(input int k);
    @(posedge clk);
    toggle <= 3'b001 << k;
    @(posedge clk);
    toggle <= 3'b000;
  endtask
  task automatic pulse(input int k, input int h);
    tog(k);
    repeat (h) @(posedge clk);
    tog(k);
    repeat (h) @(posedge clk);
  endtask
  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      num_errors++;
      $display("wrong value at %0t: irq count %0d not %0d", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("%0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ============================================================
  // Result watcher
  always @(posedge clk) begin
    rd_d <= reg_rd;
    for (int k = 0; k < 3; k++) if (irq_req[k] === 1'b1) irq_cnt[k]++;
    if (rd_d === 1'b1) begin
      exp_v = exp_q.pop_front();
      comparisons++;
      if (reg_rdata !== exp_v) begin
        num_errors++;
        $display("wrong value at %0t: read %h not %h", $time, reg_rdata, exp_v);
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      $display("wrong value at %0t: run too long", $time);
      wrap_up();
    end
  end
  // ============================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    toggle = 3'b000;
    rd_d = 1'b0;
    lfsr = 16'h000d;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(EPTM_ADDR_MODE0, 16'h0000);
    rd(EPTM_ADDR_TMR0, 16'h0000);
    rd(EPTM_ADDR_START, 16'h0000);
    rd(4'h3, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(EPTM_ADDR_PERIPH, 16'h0084);
    rd(EPTM_ADDR_PERIPH, 16'h0084);
    $display("test reset done");
    lfsr = lfsr_next(lfsr);
    n = {14'h0000, lfsr[1:0]} + 16'h0001;
    wr(EPTM_ADDR_MODE1, 16'h0005);
    wr(EPTM_ADDR_TMR1, n);
    rd(EPTM_ADDR_TMR1, n);
    wr(EPTM_ADDR_START, 16'h0002);
    pulse(1, 4);
    repeat (6) @(posedge clk);
    rd(EPTM_ADDR_TMR1, n - 16'h0001);
    repeat (n) pulse(1, 4);
    repeat (6) @(posedge clk);
    rd(EPTM_ADDR_TMR1, n);
    chk_cnt(irq_cnt[1], 1);
    wr(EPTM_ADDR_TMR1, 16'h0007);
    rd(EPTM_ADDR_TMR1, n);
    repeat (n + 1) pulse(1, 4);
    repeat (6) @(posedge clk);
    rd(EPTM_ADDR_TMR1, 16'h0007);
    chk_cnt(irq_cnt[1], 2);
    wr(EPTM_ADDR_START, 16'h0000);
    pulse(1, 4);
    repeat (6) @(posedge clk);
    rd(EPTM_ADDR_TMR1, 16'h0007);
    chk_cnt(irq_cnt[1], 2);
    $display("test event count done");
    // Channel 2 underflows drive channel 0, reload 0
    wr(EPTM_ADDR_MODE0, 16'h0011);
    wr(EPTM_ADDR_TMR0, 16'h0000);
    exp1 = 0;
    for (int e = 0; e < 3; e++) begin
      wr(EPTM_ADDR_START, 16'h0000);
      wr(EPTM_ADDR_TMR2, 16'h0001);
      wr(EPTM_ADDR_MODE2, 16'(e * 4 + 1));
      wr(EPTM_ADDR_START, 16'h0005);
      repeat (2) pulse(2, 4);
      repeat (6) @(posedge clk);
      exp1 = exp1 + ((e == 2) ? 2 : 1);
      rd(EPTM_ADDR_TMR2, 16'h0001);
      chk_cnt(irq_cnt[2], exp1);
      chk_cnt(irq_cnt[0], exp1);
    end
    $display("test edge select done");
    wr(EPTM_ADDR_START, 16'h0000);
    wr(EPTM_ADDR_MODE2, 16'h0006);
    wr(EPTM_ADDR_START, 16'h0004);
    repeat (3) pulse(2, 6);
    repeat (6) @(posedge clk);
    chk_cnt(irq_cnt[2], exp1 + 2);
    rd(EPTM_ADDR_TMR2, 16'h000f);
    wr(EPTM_ADDR_TMR2, 16'h1234);
    rd(EPTM_ADDR_TMR2, 16'h000f);
    for (int i = 0; i < 70000 && irq_cnt[2] == exp1 + 2; i++) begin
      @(posedge clk);
    end
    chk_cnt(irq_cnt[2], exp1 + 3);
    rd(EPTM_ADDR_MODE2, 16'h0026);
    wr(EPTM_ADDR_MODE2, 16'h0006);
    repeat (4) @(posedge clk);
    rd(EPTM_ADDR_MODE2, 16'h0006);
    $display("test measure done");
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    rd(EPTM_ADDR_START, 16'h0004);
    repeat (3) @(posedge clk);
    $display("test freeze done");
    wrap_up();
  end
endmodule
